//--- verilog/svop_pkg.sv
// Constants, register map and carrier types of the video output port.
// Assumes a single 200 MHz clock that is also the master clock.
`default_nettype none
package svop_pkg;
    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] SVOP_OFS_VMODE  = 8'h00;
    localparam logic [7:0] SVOP_OFS_HDIV   = 8'h04;
    localparam logic [7:0] SVOP_OFS_STATUS = 8'h08;
    localparam logic [7:0] SVOP_OFS_COLST  = 8'h10;
    // Values after reset.
    localparam logic [19:0] SVOP_VMODE_RST = 20'h00000;
    localparam logic [7:0]  SVOP_HDIV_RST  = 8'h04;
    localparam logic [7:0]  SVOP_COLST_RST = 8'h00;
    // Fewest clk cycles per horizontal clock period.
    localparam logic [7:0]  SVOP_HDIV_MIN  = 8'h04;
    // Fixed part of the first-pixel delay in slave mode, in clk cycles.
    localparam logic [8:0]  SVOP_ROW_BASE  = 9'h07C;
    // Cycles spent in the trigger synchroniser and edge detector.
    localparam logic [8:0]  SVOP_SYNC_LAT  = 9'h002;
    // Sync pulse length in horizontal clock periods.
    localparam logic [2:0]  SVOP_PULSE_LEN = 3'h4;

    // Fields of the video mode register, highest bit first.
    typedef struct packed {
        logic       fr_trig_low;   // Bit 19: frame trigger active low.
        logic       row_trig_low;  // Bit 18: row trigger active low.
        logic       slave;         // Bit 17: sync pins become triggers.
        logic       tri_unused;    // Bit 16: float pins the map leaves.
        logic [1:0] width;         // 15:14: 0 = 12, 1 = 10, 2/3 = 8 bits.
        logic [1:0] shift;         // 13:12: digital gain by left shift.
        logic [3:0] dummy;         // 11:8: dummy words before each row.
        logic       odd_even;      // Bit 7: frame sync shows the field.
        logic       vs_act_high;   // Bit 6: frame sync active high.
        logic       vs_pulse;      // Bit 5: frame sync pulse mode.
        logic       hs_act_low;    // Bit 4: row sync active low.
        logic       hs_pulse;      // Bit 3: row sync pulse mode.
        logic       edge_fall;     // Bit 2: data on falling clock edge.
        logic       data_ready;    // Bit 1: pixel clock pulses per word.
        logic       out_disable;   // Bit 0: output_disable_bit.
    } svop_vmode_t;

    // One word from the internal pixel framer with its row markers.
    typedef struct packed {
        logic        sof;
        logic        sor;
        logic        eol;
        logic        eof;
        logic        odd;
        logic [11:0] data;
    } svop_pix_t;

    typedef enum logic [1:0] {
        SVOP_IDLE   = 2'b00,
        SVOP_DUMMY  = 2'b01,
        SVOP_ACTIVE = 2'b10,
        SVOP_HTAIL  = 2'b11
    } svop_state_t;
endpackage
`default_nettype wire

//--- verilog/svop_port.sv
// Video output port: pixel bus, pixel clock, row and frame sync pins.
// Assumes clk is the master clock; pixel words come from logic on clk.
//
// The Wishbone register port and the register addresses were decided locally.
`default_nettype none
// What this block does
// - Drive 12-bit data with three sync signals.
// - Master mode after reset; slave by configuration.
// - Disable bit floats the whole data bus.
// - Shift switch maps pixel word onto pins.
// - Optionally float pins the mapping leaves unused.
// - Free-running clock with data on launch edge.
// - Data-ready clock pulses once per valid word.
// - Defaults: free running, rising launch, one hclk.
// - Configuration picks rising or falling launch edge.
// - Level row sync spans row, clock aligned.
// - Row sync active high by default.
// - Pulse row sync at row end, four hclk.
// - Zero to fifteen dummy words before rows.
// - Level frame sync spans the frame.
// - Pulse frame sync at frame end, four hclk.
// - Frame sync active low by default.
// - Odd/even mode shows field on frame sync.
// - Slave mode: sync pins become trigger inputs.
// - First pixel 124 plus column start after trigger.
// - Row trigger polarity programmable, default high.
// - Frame trigger resets the row address counter.
// - All timing runs from the master clock.
// - Column start register at 10h, reset 00h.
module svop_port
    import svop_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk,
    input  wire logic        rst_b,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    // Pixel framer side.
    input  wire logic        pix_vld,
    input  wire svop_pix_t   pix,
    output var  logic        pix_take,
    output var  logic        row_go,
    output var  logic        frame_rst,
    // Video pins.
    output var  logic [11:0] vid_d_o,
    output var  logic [11:0] vid_d_oe,
    output var  logic        pclk_o,
    output var  logic        hsync_o,
    output var  logic        hsync_oe,
    input  wire logic        hsync_i,
    output var  logic        vsync_o,
    output var  logic        vsync_oe,
    input  wire logic        vsync_i
);
    svop_vmode_t vmode_q;
    logic [7:0]  hdiv_q;
    logic [7:0]  colst_q;
    logic [7:0]  hcnt_q;
    logic        tick;
    logic        half;
    svop_state_t st_q;
    logic [3:0]  dcnt_q;
    logic [11:0] word_q;
    logic        wvld_q;
    logic        row_on_q;
    logic        frame_on_q;
    logic        odd_q;
    logic [2:0]  htail_q;
    logic [2:0]  vtail_q;
    logic        launch_lvl;
    logic        start_row;
    logic [1:0]  rt_sync_q;
    logic [1:0]  ft_sync_q;
    logic        rt_prev_q;
    logic        ft_prev_q;
    logic        rt_act;
    logic        ft_act;
    logic [8:0]  rcnt_q;
    logic [8:0]  row_delay;
    logic        feof_q;

    // Merge a write into a register honouring the byte enables.
    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] nw,
                                           input logic [3:0]  sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // Pin mask of the bits the selected receiver width uses.
    function automatic logic [11:0] used_mask(input logic [1:0] w);
        case (w)
            2'h0:    used_mask = 12'hFFF;
            2'h1:    used_mask = 12'hFFC;
            default: used_mask = 12'hFF0;
        endcase
    endfunction

    logic wb_req;
    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Bus answer: one wait state, ack for exactly one cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= wb_req;
            case (wb_adr_i)
                SVOP_OFS_VMODE:  wb_dat_o <= {12'h000, vmode_q};
                SVOP_OFS_HDIV:   wb_dat_o <= {24'h000000, hdiv_q};
                SVOP_OFS_STATUS: wb_dat_o <= {26'h0000000, st_q,
                                              rcnt_q != 9'h000, odd_q,
                                              frame_on_q, row_on_q};
                SVOP_OFS_COLST:  wb_dat_o <= {24'h000000, colst_q};
                default:         wb_dat_o <= 32'h00000000;
            endcase
        end
    end

    // Register writes; unmapped addresses are acknowledged and ignored.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vmode_q <= SVOP_VMODE_RST;
            hdiv_q  <= SVOP_HDIV_RST;
            colst_q <= SVOP_COLST_RST;
        end else if (wb_req && wb_we_i) begin
            case (wb_adr_i)
                SVOP_OFS_VMODE: vmode_q <= 20'(wmerge({12'h000, vmode_q},
                                          wb_dat_i, wb_sel_i));
                SVOP_OFS_HDIV:  hdiv_q <= 8'(wmerge({24'h000000, hdiv_q},
                                          wb_dat_i, wb_sel_i));
                SVOP_OFS_COLST: colst_q <= 8'(wmerge({24'h000000, colst_q},
                                          wb_dat_i, wb_sel_i));
                default: ;
            endcase
        end
    end

    // Horizontal clock divider; every slower rate is an enable pulse.
    // Short settings are clamped so the framer has time to advance.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hcnt_q <= 8'h00;
        end else if (hcnt_q + 8'h01 >= hdiv_q &&
                     hcnt_q + 8'h01 >= SVOP_HDIV_MIN) begin
            hcnt_q <= 8'h00;
        end else begin
            hcnt_q <= hcnt_q + 8'h01;
        end
    end
    assign tick       = (hcnt_q == 8'h00);
    assign half       = (hcnt_q == (hdiv_q < SVOP_HDIV_MIN ?
                                    SVOP_HDIV_MIN : hdiv_q) >> 1);
    assign launch_lvl = !vmode_q.edge_fall;
    assign start_row  = pix_vld && pix.sor &&
                        vtail_q == 3'h0 && htail_q == 3'h0;

    // Row sequencer: dummy words, then real words up to the row end.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q       <= SVOP_IDLE;
            dcnt_q     <= 4'h0;
            word_q     <= 12'h000;
            wvld_q     <= 1'b0;
            row_on_q   <= 1'b0;
            frame_on_q <= 1'b0;
            odd_q      <= 1'b0;
            htail_q    <= 3'h0;
            vtail_q    <= 3'h0;
            feof_q     <= 1'b0;
            pix_take   <= 1'b0;
        end else begin
            pix_take <= 1'b0;
            if (tick) begin
                wvld_q <= 1'b0;
                if (htail_q != 3'h0) begin
                    htail_q <= htail_q - 3'h1;
                end
                if (vtail_q != 3'h0) begin
                    vtail_q <= vtail_q - 3'h1;
                end
                case (st_q)
                    SVOP_IDLE: begin
                        if (start_row && vmode_q.dummy != 4'h0) begin
                            // Row sync rises with the first dummy word.
                            row_on_q <= 1'b1;
                            if (pix.sof) begin
                                frame_on_q <= 1'b1;
                                odd_q      <= pix.odd;
                            end
                            word_q <= 12'h000;
                            wvld_q <= 1'b1;
                            dcnt_q <= vmode_q.dummy - 4'h1;
                            st_q   <= (vmode_q.dummy == 4'h1) ?
                                      SVOP_ACTIVE : SVOP_DUMMY;
                        end else if (start_row) begin
                            st_q <= SVOP_ACTIVE;
                        end
                    end
                    SVOP_DUMMY: begin
                        // The last dummy is loaded here, so the first real
                        // word follows it with no empty period between.
                        word_q <= 12'h000;
                        wvld_q <= 1'b1;
                        dcnt_q <= dcnt_q - 4'h1;
                        if (dcnt_q == 4'h1) begin
                            st_q <= SVOP_ACTIVE;
                        end
                    end
                    SVOP_ACTIVE: begin
                        if (pix_vld) begin
                            word_q   <= pix.data << vmode_q.shift;
                            wvld_q   <= 1'b1;
                            pix_take <= 1'b1;
                            // With no dummies the syncs rise together with
                            // the first real word, not a period ahead.
                            if (pix.sor) begin
                                row_on_q <= 1'b1;
                                if (pix.sof) begin
                                    frame_on_q <= 1'b1;
                                    odd_q      <= pix.odd;
                                end
                            end
                            if (pix.eol) begin
                                st_q <= SVOP_HTAIL;
                            end
                            if (pix.eof) begin
                                feof_q  <= 1'b1;
                                vtail_q <= vmode_q.vs_pulse ?
                                           SVOP_PULSE_LEN : 3'h0;
                            end
                        end
                    end
                    SVOP_HTAIL: begin
                        // The last word launches on this same tick; the
                        // frame level only ends after the frame's last row.
                        row_on_q <= 1'b0;
                        if (feof_q) begin
                            frame_on_q <= 1'b0;
                            feof_q     <= 1'b0;
                        end
                        htail_q <= vmode_q.hs_pulse ?
                                   SVOP_PULSE_LEN : 3'h0;
                        st_q    <= SVOP_IDLE;
                    end
                    default: st_q <= SVOP_IDLE;
                endcase
            end
        end
    end

    // Pixel clock: goes to its launch level with each launched word and
    // back at mid period; in data-ready mode only valid words pulse.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pclk_o <= 1'b0;
        end else if (tick) begin
            pclk_o <= (!vmode_q.data_ready || wvld_q) ?
                      launch_lvl : !launch_lvl;
        end else if (half) begin
            pclk_o <= !launch_lvl;
        end
    end

    // Data and sync pins load together on the launch edge, so in free-running
    // mode every sync change is aligned to the active pixel clock edge.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vid_d_o <= 12'h000;
            hsync_o <= 1'b0;
            vsync_o <= 1'b1;
        end else if (tick) begin
            if (wvld_q) begin
                vid_d_o <= word_q;
            end
            hsync_o <= (vmode_q.hs_pulse ? htail_q != 3'h0 : row_on_q)
                       ^ vmode_q.hs_act_low;
            if (vmode_q.odd_even) begin
                vsync_o <= !(odd_q ^ vmode_q.vs_act_high);
            end else begin
                vsync_o <= !((vmode_q.vs_pulse ? vtail_q != 3'h0
                                               : frame_on_q)
                             ^ vmode_q.vs_act_high);
            end
        end
    end

    // Output enables follow configuration every cycle, not per period.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            vid_d_oe <= 12'h000;
            hsync_oe <= 1'b0;
            vsync_oe <= 1'b0;
        end else begin
            vid_d_oe <= vmode_q.out_disable ? 12'h000 :
                        (vmode_q.tri_unused ? used_mask(vmode_q.width)
                                            : 12'hFFF);
            hsync_oe <= !vmode_q.slave;
            vsync_oe <= !vmode_q.slave;
        end
    end

    // Trigger pins cross in through two flip-flops each.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rt_sync_q <= 2'b00;
            ft_sync_q <= 2'b00;
            rt_prev_q <= 1'b0;
            ft_prev_q <= 1'b0;
        end else begin
            rt_sync_q <= {rt_sync_q[0], hsync_i};
            ft_sync_q <= {ft_sync_q[0], vsync_i};
            rt_prev_q <= rt_act;
            ft_prev_q <= ft_act;
        end
    end
    assign rt_act    = rt_sync_q[1] ^ vmode_q.row_trig_low;
    assign ft_act    = ft_sync_q[1] ^ vmode_q.fr_trig_low;
    assign row_delay = SVOP_ROW_BASE + {1'b0, colst_q} - SVOP_SYNC_LAT;

    // Slave timing: the framer starts a row only when the delay ends.
    // A held trigger is seen once; row_go and frame_rst each pulse for one cycle.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rcnt_q    <= 9'h000;
            row_go    <= 1'b0;
            frame_rst <= 1'b0;
        end else begin
            row_go    <= 1'b0;
            frame_rst <= vmode_q.slave && ft_act && !ft_prev_q;
            if (vmode_q.slave && rt_act && !rt_prev_q) begin
                rcnt_q <= row_delay;
            end else if (rcnt_q != 9'h000) begin
                rcnt_q <= rcnt_q - 9'h001;
                row_go <= (rcnt_q == 9'h002);
            end
        end
    end

    // Helper for checking: cycles since the last accepted row trigger.
    logic [8:0] since_q;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            since_q <= 9'h000;
        end else if (vmode_q.slave && rt_act && !rt_prev_q) begin
            since_q <= 9'h001;
        end else if (since_q != 9'h1FF) begin
            since_q <= since_q + 9'h001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_ack_once;
        wb_ack_o ##1 !wb_ack_o;
    endsequence

    a_bus_ack_once: assert property (s_req |=> s_ack_once)
        else $error("bus ack not a single pulse");
    a_bus_float: assert property (vmode_q.out_disable |=>
        vid_d_oe == 12'h000) else $error("data bus driven while off");
    a_unused_float: assert property (!vmode_q.out_disable &&
        vmode_q.tri_unused && vmode_q.width == 2'h2 |=>
        vid_d_oe == 12'hFF0) else $error("unused pins driven");
    a_slave_inputs: assert property (vmode_q.slave |=>
        !hsync_oe && !vsync_oe) else $error("sync pins driven in slave");
    a_pclk_free: assert property (tick && !vmode_q.data_ready |=>
        pclk_o == $past(launch_lvl)) else $error("free clock missed edge");
    a_pclk_ready: assert property (tick && vmode_q.data_ready &&
        !wvld_q |=> pclk_o == !$past(launch_lvl))
        else $error("pixel clock pulsed with no word");
    a_first_pixel: assert property (row_go |->
        since_q == row_delay) else $error("row start delay wrong");
    a_frame_reset: assert property (vmode_q.slave && ft_act &&
        !ft_prev_q |=> frame_rst) else $error("frame trigger lost");
    a_hs_pulse_len: assert property (tick && vmode_q.hs_pulse &&
        htail_q != 3'h0 |=> hsync_o == !$past(vmode_q.hs_act_low))
        else $error("row sync pulse too short");
endmodule
`default_nettype wire

//--- verif/svop_framer.sv
// Pixel framer model that feeds the video port one row at a time.
// Assumes the port pulses pix_take once for each word it consumes.
`default_nettype none
module svop_framer
    import svop_pkg::*;
(
    // Clock and reset.
    input  wire logic      clk,
    input  wire logic      rst_b,
    // Word handshake.
    input  wire logic      pix_take,
    output var  logic      pix_vld,
    output var  svop_pix_t pix
);
    timeunit 1ns;
    timeprecision 1ps;
    int          left;
    int          idx;
    logic [11:0] base_q;
    logic        frame_q;
    logic        junk_q;

    // Queues one row on a clock edge; the port sees it from the next one.
    task automatic send(input int n, input logic [11:0] b, input logic fr);
        idx <= 0;
        base_q <= b;
        frame_q <= fr;
        left <= n;
    endtask

    // Advance on each take; junk toggles so idle words never look stable.
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            left <= 0;
            idx <= 0;
            junk_q <= 1'b0;
        end else begin
            junk_q <= ~junk_q;
            if (pix_take && left > 0) begin
                idx <= idx + 1;
                left <= left - 1;
            end
        end
    end

    // Present the current word and its markers; no word means noise.
    always_comb begin
        pix_vld = (left > 0);
        pix = {17{junk_q}};
        if (left > 0) begin
            pix.data = 12'(base_q + idx[11:0]);
            pix.sor = (idx == 0);
            pix.sof = frame_q && (idx == 0);
            pix.eol = (left == 1);
            pix.eof = frame_q && (left == 1);
            pix.odd = base_q[11]; // The base's top bit picks the field.
        end
    end
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Self-checking bench for the video output port with a framer model.
// Assumes one 200 MHz clock and Wishbone access to the mode registers.
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("[ERR] t=%0t got=%0h exp=%0h", $time, g, e); end end
module tb_top
    import svop_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk;
    logic        rst_b = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [7:0]  wb_adr_i = 8'h00;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic        wb_ack_o, pix_vld, pix_take, row_go, frame_rst, pclk_o;
    svop_pix_t   pix;
    logic [11:0] vid_d_o, vid_d_oe;
    logic        hsync_o, hsync_oe, vsync_o, vsync_oe;
    logic        hsync_i = 1'b0, vsync_i = 1'b0, hact = 1'b1, efall = 1'b0;
    int          mismatches = 0, n_tests = 0, cyc_n = 0, pcnt = 0;
    int          hlen = 0, hmax = 0, vlen = 0, vmax = 0, nr, nf;
    logic [11:0] cap[$];
    logic        vcap[$];
    svop_vmode_t vm;

    svop_port i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pix_vld(pix_vld), .pix(pix),
        .pix_take(pix_take), .row_go(row_go), .frame_rst(frame_rst),
        .vid_d_o(vid_d_o), .vid_d_oe(vid_d_oe), .pclk_o(pclk_o),
        .hsync_o(hsync_o), .hsync_oe(hsync_oe), .hsync_i(hsync_i),
        .vsync_o(vsync_o), .vsync_oe(vsync_oe), .vsync_i(vsync_i));
    svop_framer i_frm (.clk(clk), .rst_b(rst_b), .pix_take(pix_take),
        .pix_vld(pix_vld), .pix(pix));

    // Free-running 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Words are taken as the clock leaves its launch level, mid-period.
    always @(pclk_o) begin
        if (pclk_o === efall && hsync_o === hact) begin
            cap.push_back(vid_d_o);
            vcap.push_back(vsync_o);
        end
    end

    // Pixel clock pulses are counted for the data-ready case.
    always @(posedge pclk_o) pcnt++;

    // Longest sync pulses, and a ceiling on the whole run.
    always @(posedge clk) begin
        cyc_n++;
        hlen = (hsync_o === hact) ? hlen + 1 : 0;
        vlen = (vsync_o === 1'b0) ? vlen + 1 : 0;
        if (hlen > hmax) hmax = hlen;
        if (vlen > vmax) vmax = vlen;
        if (cyc_n == 40000) begin
            mismatches++;
            $display("[ERR] t=%0t timeout got=%0h exp=%0h", $time, cyc_n, 0);
            end_sim();
        end
    end

    // One classic Wishbone cycle; read data lands in q.
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        do @(posedge clk); while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    // Sends one row and lets its sync tail run out before returning.
    task automatic row(input int n, input logic [11:0] b, input logic fr);
        int k;
        cap.delete();
        vcap.delete();
        pcnt = 0;
        hmax = 0;
        vmax = 0;
        i_frm.send(n, b, fr);
        @(posedge clk);
        k = 0;
        while (i_frm.left != 0 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        repeat (200) @(posedge clk);
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("comparisons=%0d mismatches=%0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence.
    initial begin
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1;
        `CHK(vid_d_oe, 12'hFFF)
        `CHK({hsync_oe, vsync_oe}, 2'b11)
        `CHK({hsync_o, vsync_o}, 2'b01)
        wb(1'b0, SVOP_OFS_VMODE, 32'h0);
        `CHK(q, 32'(SVOP_VMODE_RST))
        wb(1'b0, SVOP_OFS_COLST, 32'h0);
        `CHK(q, 32'h0000_0000)
        wb(1'b0, 8'h0C, 32'h0);
        `CHK(q, 32'h0000_0000)
        wb(1'b1, SVOP_OFS_COLST, 32'h0000_0105);
        wb(1'b0, SVOP_OFS_COLST, 32'h0);
        `CHK(q, 32'h0000_0005)
        // Default mode: free clock, level syncs, whole frame in one row.
        row(4, 12'h5A1, 1'b1);
        `CHK(cap.size(), 4)
        `CHK(pcnt > 40, 1'b1)
        for (int i = 0; i < 4; i++) begin
            `CHK(cap[i], 12'(12'h5A1 + i))
            `CHK(vcap[i], 1'b0)
        end
        // Gain by one bit, 10-bit width, two dummy words first.
        vm = '0;
        vm.shift = 2'h1;
        vm.width = 2'h1;
        vm.dummy = 4'h2;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        row(3, 12'hA01, 1'b0);
        `CHK(cap.size(), 5)
        for (int i = 0; i < 3; i++) begin
            `CHK(cap[i + 2], 12'((12'hA01 + i) << 1))
        end
        vm = '0;
        vm.width = 2'h2;
        vm.tri_unused = 1'b1;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        repeat (2) @(posedge clk);
        `CHK($countones(vid_d_oe), 8)
        vm.out_disable = 1'b1;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        repeat (2) @(posedge clk);
        `CHK(vid_d_oe, 12'h000)
        // Data-ready clock with pulse syncs at row and frame end.
        vm = '0;
        vm.data_ready = 1'b1;
        vm.hs_pulse = 1'b1;
        vm.vs_pulse = 1'b1;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        row(5, 12'h100, 1'b1);
        `CHK(pcnt, 5)
        `CHK(hmax >= 16, 1'b1)
        `CHK(vmax >= 16, 1'b1)
        // Falling launch edge, both syncs inverted, odd field frame.
        vm = '0;
        vm.edge_fall = 1'b1;
        vm.hs_act_low = 1'b1;
        vm.vs_act_high = 1'b1;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        repeat (8) @(posedge clk);
        hact <= 1'b0;
        efall <= 1'b1;
        row(2, 12'h9C0, 1'b1);
        `CHK(cap.size(), 2)
        `CHK({cap[0], cap[1]}, {12'h9C0, 12'h9C1})
        `CHK({vcap[0], vcap[1]}, 2'b11)
        vm.odd_even = 1'b1;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        repeat (8) @(posedge clk);
        `CHK(vsync_o, 1'b1)
        vm.vs_act_high = 1'b0;
        wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
        repeat (8) @(posedge clk);
        `CHK(vsync_o, 1'b0)
        // Slave mode with both trigger polarities.
        for (int p = 0; p < 2; p++) begin
            vm = '0;
            vm.slave = 1'b1;
            vm.row_trig_low = p[0];
            vm.fr_trig_low = p[0];
            hsync_i <= p[0];
            vsync_i <= p[0];
            wb(1'b1, SVOP_OFS_VMODE, 32'(vm));
            repeat (4) @(posedge clk);
            `CHK({hsync_oe, vsync_oe}, 2'b00)
            @(posedge clk);
            hsync_i <= ~p[0];
            vsync_i <= ~p[0];
            nr = 0;
            nf = 0;
            for (int n = 1; n < 400 && nr == 0; n++) begin
                @(posedge clk);
                if (n == 1) vsync_i <= p[0];
                if (n == 2) hsync_i <= p[0];
                #1;
                if (frame_rst === 1'b1 && nf == 0) nf = n;
                if (row_go === 1'b1) nr = n;
            end
            `CHK(nf, 3)
            `CHK(nr, 129)
        end
        end_sim();
    end
endmodule
`default_nettype wire
